// ---- design/nrp_host.sv ----
/*
  nrp_host: host controller sequencing read, cache read, random output,
  page program and random input on a raw parallel flash bus.
  Assumes flash pins are synchronous to i_clk; one clock, pins decoded from registered state except write data, passed straight from i_wr_data.
*/
// Overview of operation
// R1: device powers up in read mode
// R2: first access after read is random
// R3: busy low during page load, then high
// R4: each read strobe gives next column
// R5: random output jumps column, repeatable
// R6: random output refused during cache read
// R7: device prefetches next page in cache read
// R8: cache read: setup, address, confirm 31h
// R9: cache read start column must be zero
// R10: busy low only during cache latency
// R11: status shows op done and ready
// R12: exit during prefetch outputs no pages
// R13: partial program of 1 to 2112 bytes
// R14: at most four partial programs per page; the count restarts whenever another row is programmed
// R15: sequential input stays in one block
// R16: program: setup, address, data, confirm
// R17: random input: 85h and two columns
// R18: fail bit flags only failed zeros
// R19: only status or reset while programming
// R20: program done: ready bit and busy high
// R21: status reads persist until new command
// R22: program pages in order within block
// R23: command on io low, latch enable high
// R24: extra address cycles ignored by device
// R25: exit 34h accepted during cache busy
// R26: wait for ready before data or op
`timescale 1ns/10ps
`default_nettype none
module nrp_host #(
  parameter int ADDR_CYCLES = 5,
  parameter int PAGE_BYTES = nrp_pkg::PAGE_BYTES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [2:0] i_req_op,
  input wire logic [39:0] i_req_addr,
  input wire logic [11:0] i_req_len,
  input wire logic [7:0] i_wr_data,
  output logic o_wr_take,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_req_error,
  output logic o_cache_active,
  output logic o_fl_cle,
  output logic o_fl_ale,
  output logic o_fl_ce_n,
  output logic o_fl_we_n,
  output logic o_fl_re_n,
  output logic [7:0] o_fl_io,
  output logic o_fl_io_oe,
  input wire logic [7:0] i_fl_io,
  input wire logic i_fl_rb
);
  // ==========================================================================
  // state encoding
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_CMD1 = 8'h02, ST_ADDR = 8'h04, ST_DATA_IN = 8'h08,
    ST_CMD2 = 8'h10, ST_WAIT_RB = 8'h20, ST_DATA_OUT = 8'h40,
    ST_DONE = 8'h80
  } nrp_state_type;
  nrp_state_type state_q;
  logic [7:0] cmd1_q, cmd2_q;
  logic [2:0] nadr_q, aidx_q;
  logic [39:0] addr_q;
  logic [11:0] cnt_q;
  logic has_cmd2_q, is_in_q, is_out_q, cache_q, loaded_q;
  logic [2:0] part_q;
  logic [23:0] pg_row_q;
  logic [7:0] rd_q;
  logic rdv_q, err_q;
  logic rb_seen_low_q;
  logic st_start, st_low, st_busy, st_done;
  // ==========================================================================
  // one strobe engine times every bus cycle
  nrp_strobe #(.PHASE(nrp_pkg::STROBE_CYC)) u_strobe (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(st_start),
    .o_low(st_low),
    .o_busy(st_busy),
    .o_done(st_done)
  );
  // ==========================================================================
  // request decode
  wire op_rd = (i_req_op == nrp_pkg::OP_READ);
  wire op_cr = (i_req_op == nrp_pkg::OP_CACHE_READ);
  wire op_ro = (i_req_op == nrp_pkg::OP_RAND_OUT);
  wire op_pg = (i_req_op == nrp_pkg::OP_PROGRAM);
  wire op_ri = (i_req_op == nrp_pkg::OP_RAND_IN);
  wire op_cx = (i_req_op == nrp_pkg::OP_CACHE_EXIT);
  wire op_st = (i_req_op == nrp_pkg::OP_STATUS);
  wire len_ok = (i_req_len != 12'h000)
    && (i_req_len <= 12'(PAGE_BYTES)); // R13
  wire col_ok = (i_req_addr[11:0] == 12'h000); // R9
  // row of the last program; only programs of that row count toward the limit
  wire same_row = (i_req_addr[39:16] == pg_row_q); // R14
  wire bad_req = (op_ro && cache_q) // R6
    || (op_cr && !col_ok) // R9
    || ((op_pg || op_ri) && !len_ok) // R13
    || (op_pg && same_row && part_q >= 3'(nrp_pkg::PARTIAL_PROG_MAX)) // R14
    || (i_req_op > nrp_pkg::OP_STATUS);
  wire take = i_req_valid && (state_q == ST_IDLE)
    && (i_fl_rb || (op_cx && cache_q)); // R26 R25
  wire [7:0] sel_cmd1 = op_pg ? nrp_pkg::CMD_PROG_SETUP :
    op_ri ? nrp_pkg::CMD_RDIN_SETUP : op_ro ? nrp_pkg::CMD_RDOUT_SETUP :
    op_cx ? nrp_pkg::CMD_CACHE_EXIT : op_st ? nrp_pkg::CMD_STATUS :
    nrp_pkg::CMD_READ_SETUP; // R23
  wire [7:0] sel_cmd2 = op_cr ? nrp_pkg::CMD_CACHE_CONFIRM :
    op_ro ? nrp_pkg::CMD_RDOUT_CONFIRM : op_pg ? nrp_pkg::CMD_PROG_CONFIRM :
    nrp_pkg::CMD_READ_CONFIRM; // R8 R16
  wire [2:0] sel_nadr = (op_ro || op_ri) ? 3'h2 : // R17 R5
    (op_rd || op_cr || op_pg) ? 3'(ADDR_CYCLES) : 3'h0; // R24
  wire [7:0] addr_byte = addr_q[8*aidx_q +: 8];
  wire cnt_last = (cnt_q == 12'h001);
  assign st_start = !st_busy && (state_q == ST_CMD1 || state_q == ST_ADDR
    || state_q == ST_CMD2 || state_q == ST_DATA_IN
    || state_q == ST_DATA_OUT);
  // ==========================================================================
  // sequencer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      cmd1_q <= 8'h00;
      cmd2_q <= 8'h00;
      nadr_q <= 3'h0;
      aidx_q <= 3'h0;
      addr_q <= 40'h0;
      cnt_q <= 12'h000;
      has_cmd2_q <= 1'b0;
      is_in_q <= 1'b0;
      is_out_q <= 1'b0;
      cache_q <= 1'b0;
      loaded_q <= 1'b0;
      part_q <= 3'h0;
      pg_row_q <= 24'h000000;
      err_q <= 1'b0;
      rb_seen_low_q <= 1'b0;
    end else begin
      err_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (take && bad_req) begin
            err_q <= 1'b1;
          end else if (take) begin
            cmd1_q <= sel_cmd1;
            cmd2_q <= sel_cmd2;
            nadr_q <= sel_nadr;
            aidx_q <= 3'h0;
            addr_q <= i_req_addr;
            cnt_q <= i_req_len;
            has_cmd2_q <= op_rd || op_cr || op_ro || op_pg;
            is_in_q <= op_pg || op_ri;
            is_out_q <= op_rd || op_cr || op_ro || op_st;
            loaded_q <= op_ri; // page already open for input
            if (op_cr) cache_q <= 1'b1;
            if (op_cx || op_rd) cache_q <= 1'b0;
            // partial count per page; other ops between do not reset it
            if (op_pg) part_q <= same_row ? part_q + 3'h1 : 3'h1; // R14 R22
            if (op_pg) pg_row_q <= i_req_addr[39:16];
            state_q <= ST_CMD1;
          end
        end
        ST_CMD1: if (st_done) begin
          state_q <= (nadr_q != 3'h0) ? ST_ADDR :
            is_in_q ? ST_DATA_IN : is_out_q ? ST_DATA_OUT : ST_DONE;
        end
        ST_ADDR: if (st_done) begin
          aidx_q <= aidx_q + 3'h1;
          if (aidx_q == nadr_q - 3'h1) begin
            state_q <= is_in_q ? ST_DATA_IN : ST_CMD2;
          end
        end
        ST_DATA_IN: if (st_done) begin
          cnt_q <= cnt_q - 12'h001;
          loaded_q <= 1'b1; // R16
          if (cnt_last) state_q <= has_cmd2_q ? ST_CMD2 : ST_DONE; // R17
        end
        ST_CMD2: if (st_done) begin
          rb_seen_low_q <= 1'b0;
          state_q <= (cmd2_q == nrp_pkg::CMD_RDOUT_CONFIRM) ? ST_DATA_OUT
            : ST_WAIT_RB; // R5
        end
        ST_WAIT_RB: begin
          if (!i_fl_rb) rb_seen_low_q <= 1'b1;
          // ready returns after load, latency or program
          if (i_fl_rb && rb_seen_low_q) begin // R3 R10 R20 R26
            state_q <= (cmd2_q == nrp_pkg::CMD_PROG_CONFIRM) ? ST_DONE
              : ST_DATA_OUT; // R2
          end
        end
        ST_DATA_OUT: if (st_done) begin
          cnt_q <= cnt_q - 12'h001; // R4
          if (cnt_last || cnt_q == 12'h000) state_q <= ST_DONE;
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // ==========================================================================
  // read data sampled while read enable is still low; the flash lets go
  // of the bus as soon as read enable rises, so a later sample is stale
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_q <= 8'h00;
      rdv_q <= 1'b0;
    end else begin
      rdv_q <= (state_q == ST_DATA_OUT) && st_done;
      if ((state_q == ST_DATA_OUT) && st_low) rd_q <= i_fl_io; // R4 R21
    end
  end
  // ==========================================================================
  // pin drive
  wire in_cmd = (state_q == ST_CMD1) || (state_q == ST_CMD2);
  wire wr_phase = in_cmd || (state_q == ST_ADDR) || (state_q == ST_DATA_IN);
  assign o_fl_cle = in_cmd; // R23
  assign o_fl_ale = (state_q == ST_ADDR);
  assign o_fl_ce_n = (state_q == ST_IDLE);
  assign o_fl_we_n = !(wr_phase && st_low); // R23
  assign o_fl_re_n = !((state_q == ST_DATA_OUT) && st_low);
  assign o_fl_io_oe = wr_phase;
  assign o_fl_io = (state_q == ST_CMD1) ? cmd1_q :
    (state_q == ST_CMD2) ? cmd2_q :
    (state_q == ST_ADDR) ? addr_byte : i_wr_data;
  assign o_wr_take = (state_q == ST_DATA_IN) && st_done;
  assign o_req_ready = (state_q == ST_IDLE)
    && (i_fl_rb || (op_cx && cache_q));
  assign o_rd_data = rd_q;
  assign o_rd_valid = rdv_q;
  assign o_req_error = err_q;
  assign o_cache_active = cache_q;
  // ==========================================================================
  // checks
  a_cmd_latch: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !o_fl_we_n |-> !(o_fl_cle && o_fl_ale)) // R23
    else $error("cle and ale both high during write");
  a_rdout_cache: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_fl_cle && o_fl_io == nrp_pkg::CMD_RDOUT_SETUP && cache_q)
    |-> (state_q != ST_CMD1)) // R6
    else $error("random output sent during cache read");
  a_prog_loaded: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_q == ST_CMD2 && cmd2_q == nrp_pkg::CMD_PROG_CONFIRM)
    |-> loaded_q) // R16
    else $error("program confirm without data");
  a_busy_wait: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_q == ST_WAIT_RB && !i_fl_rb) |=> (state_q == ST_WAIT_RB)) // R26
    else $error("left wait while busy");
  a_part_limit: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    part_q <= 3'(nrp_pkg::PARTIAL_PROG_MAX)) // R14
    else $error("partial program count exceeded");
  a_addr_count: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_q == ST_ADDR) |-> (aidx_q < nadr_q)) // R24
    else $error("extra address cycle");
  a_cache_col: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (take && op_cr && !bad_req) |-> (i_req_addr[11:0] == 12'h000)) // R9
    else $error("cache read not at column zero");
  a_rd_capture: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (state_q == ST_DATA_OUT && st_done) |=> o_rd_valid) // R4
    else $error("read strobe without data");
  c_read: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    take && op_rd);
  c_cache: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    take && op_cx && !i_fl_rb);
  c_prog: cover property (@(posedge i_clk) disable iff (!i_reset_n)
    state_q == ST_CMD2 && cmd2_q == nrp_pkg::CMD_PROG_CONFIRM);
endmodule // nrp_host
`default_nettype wire

// ---- pkg/nrp_pkg.sv ----
/*
  nrp_pkg: constants for the host-side flash sequencer.
  Assumes a raw parallel flash with 8-bit command and address cycles.
*/
package nrp_pkg;
  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_CACHE_CONFIRM = 8'h31;
  localparam logic [7:0] CMD_CACHE_EXIT = 8'h34;
  localparam logic [7:0] CMD_RDOUT_SETUP = 8'h05;
  localparam logic [7:0] CMD_RDOUT_CONFIRM = 8'he0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_RDIN_SETUP = 8'h85;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  // ==========================================================================
  // operation codes on the user port
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_CACHE_READ = 3'h1;
  localparam logic [2:0] OP_RAND_OUT = 3'h2;
  localparam logic [2:0] OP_PROGRAM = 3'h3;
  localparam logic [2:0] OP_RAND_IN = 3'h4;
  localparam logic [2:0] OP_CACHE_EXIT = 3'h5;
  localparam logic [2:0] OP_STATUS = 3'h6;
  // ==========================================================================
  // status bit positions
  localparam int SR_FAIL_BIT = 0;
  localparam int SR_OP_DONE_BIT = 5;
  localparam int SR_CTRL_READY_BIT = 6;
  // ==========================================================================
  // geometry and timing
  localparam int PAGE_BYTES = 2112;
  localparam int PARTIAL_PROG_MAX = 4;
  localparam int CLK_MHZ = 25;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
endpackage

// ---- design/nrp_strobe.sv ----
/*
  nrp_strobe: one bus cycle timer; a low phase then a high phase.
  Assumes a single clock; start is taken only while idle.
*/
`timescale 1ns/10ps
`default_nettype none
module nrp_strobe #(
  parameter int PHASE = 1
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  output logic o_low,
  output logic o_busy,
  output logic o_done
);
  // ==========================================================================
  // phase counter
  logic [7:0] cnt_q;
  logic [1:0] ph_q;
  wire last = (cnt_q == 8'(PHASE - 1));
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= 8'h00;
      ph_q <= 2'h0;
    end else if (ph_q == 2'h0) begin
      if (i_start) ph_q <= 2'h1;
      cnt_q <= 8'h00;
    end else if (last) begin
      cnt_q <= 8'h00;
      ph_q <= (ph_q == 2'h1) ? 2'h2 : 2'h0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  assign o_low = (ph_q == 2'h1);
  assign o_busy = (ph_q != 2'h0);
  assign o_done = (ph_q == 2'h2) && last;
endmodule // nrp_strobe
`default_nettype wire

// ---- tb/nrp_flash_model.sv ----
/*
  nrp_flash_model: behavioural single-page flash device, bus side.
  Assumes pins change on i_clk edges; row address is ignored.
*/
`timescale 1ns/10ps
`default_nettype none
module nrp_flash_model #(
  parameter int BUSY_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_cle,
  input wire logic i_ale,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_re_n,
  input wire logic [7:0] i_io,
  output logic [7:0] o_io,
  output logic o_rb
);
  logic [7:0] mem_q [0:4095];
  logic [11:0] col_q = 12'h000;
  logic [2:0] acnt_q = 3'h0;
  logic [7:0] busy_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [7:0] io_q = 8'h00;
  logic we_q = 1'b1;
  logic cle_q = 1'b0;
  logic ale_q = 1'b0;
  logic stat_q = 1'b0;
  logic cache_q = 1'b0;
  wire idle = (busy_q == 8'h00);
  wire [7:0] stat_byte = {1'b0, idle, idle, 5'h00};
  wire [7:0] rd_byte = stat_q ? stat_byte : mem_q[col_q];
  wire latch = !we_q && i_we_n && !i_ce_n;
  wire take_cmd = latch && cle_q && (idle || io_q == nrp_pkg::CMD_STATUS ||
    (cache_q && io_q == nrp_pkg::CMD_CACHE_EXIT));
  // ===========================================================================
  // pins: released bus shows the inverse of the last byte
  assign o_rb = idle;
  assign o_io = i_re_n ? ~last_q : rd_byte;
  initial begin
    for (int k = 0; k < 4096; k++) mem_q[k] = 8'ha5 ^ k[7:0];
  end
  // command, address, data and read strobe handling
  always @(posedge i_clk) begin
    we_q <= i_we_n;
    cle_q <= i_cle;
    ale_q <= i_ale;
    io_q <= i_io;
    if (!idle) busy_q <= busy_q - 8'h01;
    if (!i_re_n) last_q <= rd_byte;
    if (!i_re_n && !stat_q) col_q <= col_q + 12'h001;
    if (take_cmd) begin
      acnt_q <= 3'h0;
      stat_q <= io_q == nrp_pkg::CMD_STATUS ||
        io_q == nrp_pkg::CMD_PROG_CONFIRM;
      if (io_q == nrp_pkg::CMD_READ_CONFIRM) busy_q <= 8'(BUSY_CYC);
      if (io_q == nrp_pkg::CMD_CACHE_CONFIRM) busy_q <= 8'(BUSY_CYC);
      if (io_q == nrp_pkg::CMD_PROG_CONFIRM) busy_q <= 8'(BUSY_CYC);
      if (io_q == nrp_pkg::CMD_CACHE_CONFIRM) cache_q <= 1'b1;
      if (io_q == nrp_pkg::CMD_CACHE_EXIT) cache_q <= 1'b0;
    end
    if (latch && ale_q && acnt_q < 3'h5) acnt_q <= acnt_q + 3'h1;
    if (latch && ale_q && acnt_q == 3'h0) col_q[7:0] <= io_q;
    if (latch && ale_q && acnt_q == 3'h1) col_q[11:8] <= io_q[3:0];
    if (latch && !cle_q && !ale_q) begin
      mem_q[col_q] <= mem_q[col_q] & io_q;
      col_q <= col_q + 12'h001;
    end
  end
endmodule // nrp_flash_model
`default_nettype wire

// ---- tb/nrp_host_bench.sv ----
/*
  nrp_host_bench: self-checking bench for the host sequencer.
  Assumes nrp_flash_model on the flash pins and a 25 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module nrp_host_bench;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic req_valid = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [39:0] req_addr = 40'h0;
  logic [11:0] req_len = 12'h0;
  logic [7:0] wr_data = 8'h00;
  logic o_req_ready, o_wr_take, o_rd_valid, o_req_error, o_cache_active;
  logic cle, ale, ce_n, we_n, re_n, io_oe, rb;
  logic [7:0] o_rd_data, host_io, dev_io;
  wire [7:0] fl_bus = io_oe ? host_io : dev_io;
  logic [7:0] got_q [$];
  logic got_err;
  int take_count = 0;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  // ===========================================================================
  // clock, timeout
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      report_and_stop();
    end
  end
  nrp_host nrp_host_inst (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_req_valid(req_valid), .o_req_ready(o_req_ready), .i_req_op(req_op),
    .i_req_addr(req_addr), .i_req_len(req_len), .i_wr_data(wr_data),
    .o_wr_take(o_wr_take), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_req_error(o_req_error), .o_cache_active(o_cache_active),
    .o_fl_cle(cle), .o_fl_ale(ale), .o_fl_ce_n(ce_n), .o_fl_we_n(we_n),
    .o_fl_re_n(re_n), .o_fl_io(host_io), .o_fl_io_oe(io_oe),
    .i_fl_io(fl_bus), .i_fl_rb(rb));
  nrp_flash_model nrp_flash_model_inst (.i_clk(i_clk), .i_cle(cle),
    .i_ale(ale), .i_ce_n(ce_n), .i_we_n(we_n), .i_re_n(re_n),
    .i_io(fl_bus), .o_io(dev_io), .o_rb(rb));
  // ===========================================================================
  // request driver and comparisons
  task automatic run_op(input logic [2:0] op, input logic [39:0] a,
      input logic [11:0] n, input logic [7:0] wd);
    bit fin;
    fin = 1'b0;
    got_q.delete();
    got_err = 1'b0;
    take_count = 0;
    req_op <= op;
    req_addr <= a;
    req_len <= n;
    wr_data <= wd;
    req_valid <= 1'b1;
    do @(posedge i_clk); while (o_req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (int k = 0; k < 9000; k++) begin
      @(posedge i_clk);
      if (o_rd_valid === 1'b1) got_q.push_back(o_rd_data);
      if (o_req_error === 1'b1) got_err = 1'b1;
      if (o_wr_take === 1'b1) take_count++;
      if (k > 2 && o_req_ready === 1'b1) begin
        fin = 1'b1;
        break;
      end
    end
    check_bit(fin, 1'b1);
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic check_read(input logic [11:0] c, input int n,
      input logic [7:0] m);
    logic [11:0] p;
    check_byte(got_q.size(), n);
    for (int i = 0; i < n && i < got_q.size(); i++) begin
      p = c + i;
      check_byte(got_q[i], (8'ha5 ^ p[7:0]) & m);
    end
  endtask
  // ===========================================================================
  // scenarios
  task automatic t_read();
    run_op(nrp_pkg::OP_READ, 40'h0000010003, 12'h004, 8'h00);
    check_read(12'h003, 4, 8'hff);
    run_op(nrp_pkg::OP_RAND_OUT, 40'h0000000040, 12'h003, 8'h00);
    check_read(12'h040, 3, 8'hff);
    run_op(nrp_pkg::OP_RAND_OUT, 40'h0000000010, 12'h001, 8'h00);
    check_read(12'h010, 1, 8'hff);
    $display("test read done");
  endtask
  task automatic t_program();
    run_op(nrp_pkg::OP_PROGRAM, 40'h0000010000, 12'h000, 8'h0f);
    check_bit(got_err, 1'b1);
    run_op(nrp_pkg::OP_PROGRAM, 40'h0000010020, 12'h002, 8'h0f);
    check_bit(got_err, 1'b0);
    check_byte(take_count, 8'h02);
    run_op(nrp_pkg::OP_STATUS, 40'h0, 12'h002, 8'h00);
    check_byte(got_q[0], 8'h60);
    check_byte(got_q[1], 8'h60);
    run_op(nrp_pkg::OP_READ, 40'h0000010020, 12'h002, 8'h00);
    check_read(12'h020, 2, 8'h0f);
    run_op(nrp_pkg::OP_PROGRAM, 40'h0000010000, 12'h840, 8'hff);
    check_bit(got_err, 1'b0);
    check_bit(take_count == 2112, 1'b1);
    run_op(nrp_pkg::OP_PROGRAM, 40'h0000010030, 12'h001, 8'hf0);
    check_bit(got_err, 1'b0);
    run_op(nrp_pkg::OP_PROGRAM, 40'h0000010031, 12'h001, 8'hf0);
    check_bit(got_err, 1'b0);
    run_op(nrp_pkg::OP_PROGRAM, 40'h0000010032, 12'h001, 8'hf0);
    check_bit(got_err, 1'b1);
    run_op(nrp_pkg::OP_PROGRAM, 40'h0000020000, 12'h001, 8'hff);
    check_bit(got_err, 1'b0);
    $display("test program done");
  endtask
  task automatic t_cache();
    run_op(nrp_pkg::OP_CACHE_READ, 40'h0000020005, 12'h002, 8'h00);
    check_bit(got_err, 1'b1);
    run_op(nrp_pkg::OP_CACHE_READ, 40'h0000020000, 12'h002, 8'h00);
    check_bit(o_cache_active, 1'b1);
    check_read(12'h000, 2, 8'hff);
    run_op(nrp_pkg::OP_RAND_OUT, 40'h0000000010, 12'h001, 8'h00);
    check_bit(got_err, 1'b1);
    run_op(nrp_pkg::OP_CACHE_EXIT, 40'h0, 12'h000, 8'h00);
    check_bit(o_cache_active, 1'b0);
    $display("test cache done");
  endtask
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(posedge i_clk);
    t_read();
    t_program();
    t_cache();
    report_and_stop();
  end
endmodule // nrp_host_bench
`default_nettype wire
